// ===== pkg/cascade_params.svh
// timing and field constants for the cascade priority chain
// assumes a 100 MHz core clock
`ifndef CASCADE_PARAMS_SVH
`define CASCADE_PARAMS_SVH
`define CLOCK_PERIOD_NS 10
`define ID_WIDTH 5
`define CHAIN_SETTLE_CYCLES 2
`define ID_END_SETTLE_US 1
`define ID_END_SETTLE_CYCLES \
  ((`ID_END_SETTLE_US * 1000 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define CMD_WIDTH 5
`endif

// ===== pkg/cascade_pkg.sv
// types for the cascade priority chain
// assumes cascade_params.svh is on the include path
`include "cascade_params.svh"
package cascade_pkg;
  typedef enum logic [`CMD_WIDTH-1:0] {
    cmd_none                 = 5'h00,
    search_cmd               = 5'h01,
    search_alt_cmd           = 5'h02,
    rebuild_hit_flags_cmd    = 5'h03,
    next_hit_cmd             = 5'h04,
    mark_hit_cmd             = 5'h05,
    mark_hit_alt_cmd         = 5'h06,
    purge_hit_cmd            = 5'h07,
    soft_reset_cmd           = 5'h08,
    rebuild_empty_flags_cmd  = 5'h09,
    next_empty_cmd           = 5'h0A,
    mark_empty_cmd           = 5'h0B,
    mark_empty_alt_cmd       = 5'h0C,
    append_then_next_empty_cmd = 5'h0D,
    append_cmd               = 5'h0E,
    begin_id_assign_cmd      = 5'h0F,
    end_id_assign_cmd        = 5'h10
  } cmd_e;
  typedef enum logic [2:0] {
    st_normal  = 3'b001,
    st_id      = 3'b010,
    st_id_exit = 3'b100
  } mode_e;
endpackage : cascade_pkg

// ===== pkg/chain_if.sv
// one priority chain stage bundle between top and chain stage
// assumes single clock domain
`timescale 1ns/1ps
interface chain_if;
  logic own_cond;
  logic chain_in;
  logic restart;
  logic chain_out;
  logic granted;
  logic settled;
  modport top   (output own_cond, output chain_in, output restart,
                 input chain_out, input granted, input settled);
  modport stage (input own_cond, input chain_in, input restart,
                 output chain_out, output granted, output settled);
endinterface : chain_if

// ===== src/chain_stage.sv
// one daisy-chain priority stage with a settle counter
// assumes restart pulses when priority must be re-propagated
`timescale 1ns/1ps
`include "cascade_params.svh"
module chain_stage
#(
  parameter int SETTLE = `CHAIN_SETTLE_CYCLES
)
(
  input  wire logic clock,
  input  wire logic rst_n,
  chain_if.stage    ch
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       out_q;
  logic       next_out_q;
  logic       grant_q;
  logic       next_grant_q;

  always_comb
  begin
    next_out_q   = ch.own_cond | ch.chain_in;
    next_grant_q = ch.own_cond & ~ch.chain_in;
    if (ch.restart)
      next_count = 8'(SETTLE);
    else if (count != 8'h00)
      next_count = count - 8'h01;
    else
      next_count = count;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count   <= 8'(SETTLE);
      out_q   <= 1'b0;
      grant_q <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      out_q   <= next_out_q;
      grant_q <= next_grant_q;
    end
  end

  assign ch.chain_out = out_q;
  assign ch.granted   = grant_q;
  assign ch.settled   = (count == 8'h00);
endmodule : chain_stage

// ===== src/cascade_priority_chain.sv
// hit, multi-hit and empty priority propagation for one cascaded device
// assumes strobes are one-cycle pulses synchronous to clock; chain pins
// are active high inside the core
`timescale 1ns/1ps
`include "cascade_params.svh"
// Operation
// - single-device commands still propagate priority down the chain
// - hit priority restarts after search, reads, hit autosteps, hit cmds, reset
// - hit chain carries hit; multihit chain serves status and port reads
// - empty priority restarts after empty autosteps, empty cmds, reset
// - search and port reads never touch empty priority
// - multihit chain carries id priority in id-assignment submode
module cascade_priority_chain
  import cascade_pkg::*;
#(
  parameter int ID_END_SETTLE = `ID_END_SETTLE_CYCLES
)
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       search_strobe,
  input  wire logic       out_read_strobe,
  input  wire logic       hit_autostep,
  input  wire logic       empty_autostep,
  input  wire logic       cmd_strobe,
  input  wire cmd_e       cmd,
  input  wire logic       local_hit,
  input  wire logic       local_multihit,
  input  wire logic       local_empty,
  input  wire logic       local_id_unassigned,
  input  wire logic       hit_chain_in,
  input  wire logic       multihit_chain_in,
  input  wire logic       empty_chain_in,
  output logic            hit_chain_out,
  output logic            multihit_chain_out,
  output logic            empty_chain_out,
  output logic            hit_priority,
  output logic            empty_priority,
  output logic            id_priority,
  output logic            hit_settled,
  output logic            empty_settled,
  output logic            multihit_valid,
  output logic            id_assign_submode
);
  // ==========================================================
  // reset release
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // restart decode
  logic hit_cmd;
  logic empty_cmd;
  logic hit_restart;
  logic empty_restart;
  logic reset_pulse;
  logic rst_seen;
  always_comb
  begin
    hit_cmd   = 1'b0;
    empty_cmd = 1'b0;
    if (cmd_strobe)
    begin
      case (cmd)
        search_cmd, search_alt_cmd, rebuild_hit_flags_cmd, next_hit_cmd,
        mark_hit_cmd, mark_hit_alt_cmd:
          hit_cmd = 1'b1;
        rebuild_empty_flags_cmd, next_empty_cmd, mark_empty_cmd,
        mark_empty_alt_cmd, append_then_next_empty_cmd:
          empty_cmd = 1'b1;
        soft_reset_cmd:
        begin
          hit_cmd   = 1'b1;
          empty_cmd = 1'b1;
        end
        default:
        begin
          hit_cmd   = 1'b0;
          empty_cmd = 1'b0;
        end
      endcase
    end
    reset_pulse = ~rst_seen;
    hit_restart = search_strobe | out_read_strobe | hit_autostep |
                  hit_cmd | reset_pulse;
    // empty restart, no search or read terms
    empty_restart = empty_autostep | empty_cmd | reset_pulse;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rst_seen <= 1'b0;
    else
      rst_seen <= 1'b1;
  end

  // ==========================================================
  // id-assignment submode
  mode_e       mode;
  mode_e       next_mode;
  logic [15:0] exit_count;
  logic [15:0] next_exit_count;
  always_comb
  begin
    next_mode       = mode;
    next_exit_count = exit_count;
    case (mode)
      st_normal:
        if (cmd_strobe && cmd == begin_id_assign_cmd)
          next_mode = st_id;
      st_id:
        if (cmd_strobe && cmd == end_id_assign_cmd)
        begin
          next_mode       = st_id_exit;
          next_exit_count = 16'(ID_END_SETTLE);
        end
      st_id_exit:
        // chain returns to multihit at once; valid flag waits for settle
        if (cmd_strobe && cmd == begin_id_assign_cmd)
          next_mode = st_id;
        else if (exit_count <= 16'h0001)
          next_mode = st_normal;
        else
          next_exit_count = exit_count - 16'h0001;
      default:
        next_mode = st_normal;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode       <= st_normal;
      exit_count <= 16'h0000;
    end
    else
    begin
      mode       <= next_mode;
      exit_count <= next_exit_count;
    end
  end

  // ==========================================================
  // chain stages
  chain_if hit_ch ();
  chain_if multi_ch ();
  chain_if empty_ch ();
  logic in_id;
  assign in_id = (mode == st_id);

  assign hit_ch.own_cond   = local_hit;
  assign hit_ch.chain_in   = hit_chain_in;
  assign hit_ch.restart    = hit_restart;
  // multihit chain carries id priority in submode
  assign multi_ch.own_cond = in_id ? local_id_unassigned :
                             (local_multihit |
                              (local_hit & hit_chain_in));
  assign multi_ch.chain_in = multihit_chain_in;
  assign multi_ch.restart  = hit_restart | (cmd_strobe &&
                             (cmd == begin_id_assign_cmd ||
                              cmd == end_id_assign_cmd));
  assign empty_ch.own_cond = local_empty;
  assign empty_ch.chain_in = empty_chain_in;
  assign empty_ch.restart  = empty_restart;

  chain_stage hit_stage (.clock(clock), .rst_n(rst_n), .ch(hit_ch));
  chain_stage multi_stage (.clock(clock), .rst_n(rst_n), .ch(multi_ch));
  chain_stage empty_stage (.clock(clock), .rst_n(rst_n), .ch(empty_ch));

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hit_chain_out      <= 1'b0;
      multihit_chain_out <= 1'b0;
      empty_chain_out    <= 1'b0;
      hit_priority       <= 1'b0;
      empty_priority     <= 1'b0;
      id_priority        <= 1'b0;
      hit_settled        <= 1'b0;
      empty_settled      <= 1'b0;
      multihit_valid     <= 1'b0;
      id_assign_submode  <= 1'b0;
    end
    else
    begin
      // local changes reach the chain outputs while chain in is inactive
      hit_chain_out      <= hit_ch.chain_out;
      multihit_chain_out <= multi_ch.chain_out;
      empty_chain_out    <= empty_ch.chain_out;
      // grant only with inactive chain in
      hit_priority       <= hit_ch.granted;
      empty_priority     <= empty_ch.granted;
      id_priority        <= in_id & multi_ch.granted;
      hit_settled        <= hit_ch.settled & ~hit_restart;
      empty_settled      <= empty_ch.settled & ~empty_restart;
      // multihit valid only in normal mode once the multihit chain has settled
      multihit_valid     <= (mode == st_normal) & multi_ch.settled;
      id_assign_submode  <= in_id;
    end
  end
endmodule : cascade_priority_chain

// ===== testbench/upstream_device.sv
// upstream neighbour: own hit, multihit, empty flags onto its chain outs
// assumes own flags come from the bench; DEPTH sets how slowly it answers
`timescale 1ns/1ps
module upstream_device
#(
  parameter int DEPTH = 1
)
(
  input  wire logic       clock,
  input  wire logic [2:0] own,
  output logic      [2:0] chain
);
  logic [2:0] pipe [DEPTH] = '{default: 3'h0};
  always @(posedge clock)
  begin
    pipe[0] <= own;
    for (int i = 1; i < DEPTH; i++)
      pipe[i] <= pipe[i - 1];
  end
  assign chain = pipe[DEPTH - 1];
endmodule : upstream_device

// ===== testbench/cascade_checker.sv
// port assertions for the cascade priority chain
// assumes it is bound into cascade_priority_chain, one clock domain
`timescale 1ns/1ps
module cascade_checker
  import cascade_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic search_strobe,
  input wire logic out_read_strobe,
  input wire logic hit_autostep,
  input wire logic empty_autostep,
  input wire logic cmd_strobe,
  input wire cmd_e cmd,
  input wire logic local_hit,
  input wire logic hit_chain_in,
  input wire logic hit_chain_out,
  input wire logic hit_priority,
  input wire logic hit_settled,
  input wire logic empty_settled,
  input wire logic multihit_valid,
  input wire logic id_assign_submode
);
  // ==========================================
  // helpers: skip the reset synchroniser window
  logic [2:0] up;
  wire ready = (up == 3'h7);
  wire quiet = !(search_strobe | out_read_strobe | hit_autostep | cmd_strobe);
  always_ff @(posedge clock or negedge resetn)
    if (!resetn) up <= 3'h0;
    else if (!ready) up <= up + 3'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_kick; ready && search_strobe; endsequence
  sequence s_calm; quiet [*6]; endsequence
  sequence s_id_begin;
    ready && cmd_strobe && cmd == begin_id_assign_cmd;
  endsequence
  sequence s_id_end;
    ready && cmd_strobe && cmd == end_id_assign_cmd && id_assign_submode;
  endsequence
  // a following id command legally moves the submode again
  sequence s_no_end;
    (!(cmd_strobe && cmd == end_id_assign_cmd)) [*2];
  endsequence
  sequence s_no_begin;
    (!(cmd_strobe && cmd == begin_id_assign_cmd)) [*2];
  endsequence
  property p_hit_out;
    ready |-> hit_chain_out == $past(local_hit | hit_chain_in, 2);
  endproperty
  a_hit_out: assert property (p_hit_out) else $error("hit out");
  property p_grant;
    ready |-> hit_priority == $past(local_hit & !hit_chain_in, 2);
  endproperty
  a_grant: assert property (p_grant) else $error("hit grant");
  property p_search;
    s_kick |-> ##2 !hit_settled;
  endproperty
  a_search: assert property (p_search) else $error("no restart");
  property p_settle;
    s_kick ##1 s_calm |-> hit_settled;
  endproperty
  a_settle: assert property (p_settle) else $error("no settle");
  // search and read leave the empty chain alone
  property p_no_empty;
    ready && (search_strobe || out_read_strobe) && empty_settled &&
      !empty_autostep && !cmd_strobe && !$past(empty_autostep) &&
      !$past(cmd_strobe) |=> empty_settled;
  endproperty
  a_no_empty: assert property (p_no_empty) else $error("empty hit");
  property p_empty_cmd;
    ready && cmd_strobe && cmd == rebuild_empty_flags_cmd
      |-> ##2 !empty_settled;
  endproperty
  a_empty_cmd: assert property (p_empty_cmd) else $error("empty");
  property p_id_on;
    s_id_begin ##1 s_no_end |=> id_assign_submode && !multihit_valid;
  endproperty
  a_id_on: assert property (p_id_on) else $error("id on");
  property p_id_off;
    s_id_end ##1 s_no_begin |=> !id_assign_submode && !multihit_valid;
  endproperty
  a_id_off: assert property (p_id_off) else $error("id off");
endmodule : cascade_checker
bind cascade_priority_chain cascade_checker u_cascade_checker (
  .clock, .resetn, .search_strobe, .out_read_strobe, .hit_autostep,
  .empty_autostep, .cmd_strobe, .cmd, .local_hit, .hit_chain_in,
  .hit_chain_out, .hit_priority, .hit_settled, .empty_settled,
  .multihit_valid, .id_assign_submode);

// ===== testbench/testbench.sv
// self-checking bench for the cascade priority chain
// assumes the checker binds itself and upstream_device feeds chain ins
`timescale 1ns/1ps
`include "cascade_params.svh"
module testbench
  import cascade_pkg::*;
;
  logic clock = 1'b0, resetn = 1'b0, search_strobe = 1'b0;
  logic out_read_strobe = 1'b0, hit_autostep = 1'b0, empty_autostep = 1'b0;
  logic cmd_strobe = 1'b0, local_hit = 1'b0, local_multihit = 1'b0;
  logic local_empty = 1'b0, local_id_unassigned = 1'b0;
  logic hit_chain_out, multihit_chain_out, empty_chain_out, hit_priority;
  logic empty_priority, id_priority, hit_settled, empty_settled;
  logic multihit_valid, id_assign_submode;
  cmd_e        cmd = cmd_none;
  logic [2:0]  up_own = 3'h0, up_chain;
  logic [31:0] seed = 32'hAAD8;
  logic [6:0]  h;
  int          err_count = 0, compares = 0, cycles = 0, hist [$];
  bit          normal = 1'b0;
  bit          want_hit, want_empty;
  cascade_priority_chain u_cascade_priority_chain (
    .clock, .resetn, .search_strobe, .out_read_strobe, .hit_autostep,
    .empty_autostep, .cmd_strobe, .cmd, .local_hit, .local_multihit,
    .local_empty, .local_id_unassigned, .hit_chain_in(up_chain[0]),
    .multihit_chain_in(up_chain[1]), .empty_chain_in(up_chain[2]),
    .hit_chain_out, .multihit_chain_out, .empty_chain_out, .hit_priority,
    .empty_priority, .id_priority, .hit_settled, .empty_settled,
    .multihit_valid, .id_assign_submode);
  upstream_device #(.DEPTH(2)) u_upstream_device (
    .clock, .own(up_own), .chain(up_chain));
  // ==========================================
  // tasks
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xorshift
  task automatic check(input logic seen, input logic want);
    compares++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch at %0t: seen %b want %b", $time, seen, want);
    end
  endtask : check
  task automatic quiet(input int n);
    @(negedge clock);
    {search_strobe, out_read_strobe, hit_autostep, empty_autostep} = 4'h0;
    cmd_strobe = 1'b0;
    repeat (n - 1) @(negedge clock);
  endtask : quiet
  task automatic issue(input cmd_e c);
    @(negedge clock);
    cmd = c;
    cmd_strobe = 1'b1;
    quiet(1);
  endtask : issue
  task automatic rand_run(input int n, input bit strobes);
    repeat (n)
    begin
      @(negedge clock);
      seed = xorshift(seed);
      {local_hit, local_multihit, local_empty, local_id_unassigned,
       up_own} = seed[6:0];
      {search_strobe, out_read_strobe, hit_autostep, empty_autostep} =
        strobes ? seed[11:8] & seed[15:12] & seed[19:16] : 4'h0;
      cmd_strobe = strobes && seed[22:20] == 3'h0;
      cmd = cmd_e'(seed[28:24]);
    end
    quiet(1);
  endtask : rand_run
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // ==========================================
  // clock, timeout and reference model
  initial
    forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (resetn) hist.push_back({local_multihit, local_hit & up_chain[0],
      local_hit, local_empty, up_chain});
    if (cycles == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  always @(negedge clock)
    if (hist.size() > 4)
    begin
      h = hist[$ - 1][6:0];
      check(hit_chain_out, h[4] | h[0]);
      check(empty_chain_out, h[3] | h[2]);
      check(hit_priority, h[4] & ~h[0]);
      check(empty_priority, h[3] & ~h[2]);
      if (normal) check(multihit_chain_out, h[6] | h[5] | h[1]);
    end
  // ==========================================
  // scenarios
  initial
  begin
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    quiet(4);
    rand_run(600, 1'b1);
    issue(end_id_assign_cmd);
    quiet(`ID_END_SETTLE_CYCLES + 10);
    $display("random done");
    issue(begin_id_assign_cmd);
    quiet(3);
    check(id_assign_submode, 1'b1);
    local_id_unassigned = 1'b1;
    up_own = 3'h0;
    quiet(6);
    check(id_priority, 1'b1);
    up_own = 3'h2;
    quiet(6);
    check(id_priority, 1'b0);
    issue(end_id_assign_cmd);
    quiet(3);
    check(multihit_valid, 1'b0);
    quiet(`ID_END_SETTLE_CYCLES + 10);
    check(multihit_valid, 1'b1);
    normal = 1'b1;
    rand_run(200, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      quiet(12);
      {empty_autostep, hit_autostep, out_read_strobe, search_strobe} =
        4'h1 << k;
      quiet(2);
      check(hit_settled, k == 3);
      check(empty_settled, k != 3);
    end
    normal = 1'b0;
    $display("id and strobes done");
    for (int c = 1; c <= 16; c++)
    begin
      quiet(12);
      issue(cmd_e'(c));
      quiet(1);
      // other commands must leave a settled chain alone
      want_hit = cmd inside {search_cmd, search_alt_cmd,
        rebuild_hit_flags_cmd, next_hit_cmd, mark_hit_cmd,
        mark_hit_alt_cmd, soft_reset_cmd};
      want_empty = cmd inside {soft_reset_cmd, rebuild_empty_flags_cmd,
        next_empty_cmd, mark_empty_cmd, mark_empty_alt_cmd,
        append_then_next_empty_cmd};
      check(hit_settled, !want_hit);
      check(empty_settled, !want_empty);
    end
    $display("commands done");
    end_of_test();
  end
endmodule : testbench
